// >>> dv/sfc_checker.sv
// Link checker: drive and timing relations on the serial link between both ends
`timescale 1ns/100ps
module sfc_checker (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Link signals
  input wire logic cs_n,
  input wire logic sck,
  input wire logic hold_n,
  input wire logic h_io0_o,
  input wire logic h_io0_oe,
  input wire logic h_io1_oe,
  input wire logic d_io0_o,
  input wire logic d_io0_oe,
  input wire logic d_io1_o,
  input wire logic d_io1_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Deselect or hold must free both lines within two cycles
  property p_cs_free; cs_n [*3] |-> !d_io0_oe && !d_io1_oe; endproperty
  a_cs_free: assert property (p_cs_free) else $error("device drives while deselected");
  property p_hold_free; (!hold_n) [*3] |-> !d_io0_oe && !d_io1_oe; endproperty
  a_hold_free: assert property (p_hold_free) else $error("device drives during hold");
  // Output bits move only one cycle after a clock fall
  property p_io1_launch; $changed(d_io1_o) && d_io1_oe && $past(d_io1_oe) && !cs_n && !$past(cs_n) |->
    !$past(sck) && $past(sck, 2); endproperty
  a_io1_launch: assert property (p_io1_launch) else $error("io1 changed off a fall");
  property p_io0_launch; $changed(d_io0_o) && d_io0_oe && $past(d_io0_oe) && !cs_n && !$past(cs_n) |->
    !$past(sck) && $past(sck, 2); endproperty
  a_io0_launch: assert property (p_io0_launch) else $error("io0 changed off a fall");
  // Turnaround: never both ends on one line
  property p_clash0; !(d_io0_oe && h_io0_oe); endproperty
  a_clash0: assert property (p_clash0) else $error("both ends drive io0");
  property p_clash1; !(d_io1_oe && h_io1_oe); endproperty
  a_clash1: assert property (p_clash1) else $error("both ends drive io1");
  // The first eight cycles of the opcode phase are input only
  property p_opc_quiet; $fell(cs_n) |-> (!d_io0_oe && !d_io1_oe) [*8]; endproperty
  a_opc_quiet: assert property (p_opc_quiet) else $error("device drives in opcode");
  // Host data settles while the clock is low, ahead of the capturing rise
  property p_host_setup; $changed(h_io0_o) && h_io0_oe && $past(h_io0_oe) && !cs_n |-> !sck && !$past(sck);
  endproperty
  a_host_setup: assert property (p_host_setup) else $error("host data moved near a rise");
endmodule : sfc_checker

// >>> dv/sfc_tb.sv
// Bench: host and flash front end joined over the serial link
`timescale 1ns/100ps
module sfc_tb;
  import sfc_pkg::*;
  localparam logic [7:0] ID_BYTE = 8'hC3; // Arbitrary value
  localparam logic [7:0] R_OP [4] = '{OP_READ, OP_FAST, OP_DOUT, OP_DIO};
  localparam logic [23:0] R_AD [4] = '{24'hAFFFFE, 24'h012345, 24'h0A0FFF, 24'hFFFFFF};
  localparam logic [7:0] C_OP [7] = '{OP_SSE_A, OP_SSE_B, OP_CE_A, OP_CE_B, OP_WREN, OP_WRDI, OP_SE};
  localparam sfc_cmd_t C_EX [7] = '{CMD_SSE, CMD_SSE, CMD_CE, CMD_CE, CMD_WR_EN, CMD_WR_DIS, CMD_SE};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic abort_n = 1'b1;
  logic hrst_n;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic [15:0] nbytes = 16'h0000;
  logic mode3 = 1'b0;
  logic hold_n = 1'b1;
  logic wp_n = 1'b1;
  logic lock = 1'b0;
  logic [7:0] wdat = 8'hA5;
  logic busy, rd_valid, prog_valid, cmd_valid, stat_ok, stat_blk, dev_mode3, pwr_dn, wr_req;
  logic [7:0] rd_data, stat_data, prog_data, small_sector;
  logic [19:0] rd_addr, prog_addr, cmd_addr;
  logic [3:0] sector;
  sfc_cmd_t cmd;
  logic [7:0] rd_q[$];
  logic [7:0] pd_q[$];
  logic [19:0] pa_q[$];
  sfc_cmd_t cmd_q[$];
  int miscompares = 0;
  int n_compared = 0;
  int n_ok = 0;
  int n_blk = 0;
  // Array contents seen by the front end
  function automatic logic [7:0] mem(input logic [19:0] a);
    return a[7:0] ^ a[19:12];
  endfunction : mem
  // Host reset doubles as a way to cut a frame short
  assign hrst_n = rst_n & abort_n;
  sfc_if link();
  sfc_host #(.HALF(4)) sfc_host_inst (.i_clk(clk), .i_reset_n(hrst_n), .link(link.host), .i_start(start),
    .i_opcode(opcode), .i_addr(addr), .i_nbytes(nbytes), .i_mode3(mode3), .i_hold_n(hold_n), .i_wp_n(wp_n),
    .i_wr_data(wdat), .o_wr_req(wr_req), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_busy(busy));
  sfc_device sfc_device_inst (.i_clk(clk), .i_reset_n(rst_n), .link(link.device), .o_rd_addr(rd_addr),
    .i_rd_data(mem(rd_addr)), .i_id_data(ID_BYTE), .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_cmd_addr(cmd_addr),
    .o_sector(sector), .o_small_sector(small_sector), .o_prog_valid(prog_valid), .o_prog_addr(prog_addr),
    .o_prog_data(prog_data), .i_status_write_lock_bit(lock), .o_stat_valid(stat_ok), .o_stat_blocked(stat_blk),
    .o_stat_data(stat_data), .o_mode3(dev_mode3), .o_power_down(pwr_dn));
  sfc_checker sfc_checker_inst (.i_clk(clk), .i_reset_n(rst_n), .cs_n(link.cs_n), .sck(link.sck),
    .hold_n(link.hold_n), .h_io0_o(link.h_io0_o), .h_io0_oe(link.h_io0_oe), .h_io1_oe(link.h_io1_oe),
    .d_io0_o(link.d_io0_o), .d_io0_oe(link.d_io0_oe), .d_io1_o(link.d_io1_o), .d_io1_oe(link.d_io1_oe));
  // Clock
  initial begin
    forever #25 clk = ~clk;
  end
  // Pulses stand one cycle, so they are caught at every edge
  always @(posedge clk) begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (prog_valid === 1'b1) pa_q.push_back(prog_addr);
    if (prog_valid === 1'b1) pd_q.push_back(prog_data);
    if (cmd_valid === 1'b1) cmd_q.push_back(cmd);
    if (stat_ok === 1'b1) n_ok++;
    if (stat_blk === 1'b1) n_blk++;
    if (wr_req === 1'b1) wdat <= wdat + 8'h01; // Each write byte differs
  end
  task automatic chkv(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chkv
  task automatic chkc(input sfc_cmd_t exp);
    n_compared++;
    if (cmd_q.size() == 0 || cmd_q[0] !== exp) begin
      miscompares++;
      $display("mismatch command expected %0d seen %0d", exp, cmd_q.size() > 0 ? cmd_q[0] : CMD_NONE);
    end
    if (cmd_q.size() > 0) cmd_q.delete(0);
  endtask : chkc
  task automatic go(input logic [7:0] op, input logic [23:0] a, input logic [15:0] n, input logic m3);
    @(posedge clk);
    start <= 1'b1;
    opcode <= op;
    addr <= a;
    nbytes <= n;
    mode3 <= m3;
    @(posedge clk);
    start <= 1'b0;
  endtask : go
  // Bounded wait for the host to close the frame
  task automatic fin;
    int k;
    k = 0;
    @(negedge clk);
    while (busy !== 1'b0 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    chkv("busy", 20'h0, 20'(busy));
    repeat (8) @(posedge clk);
  endtask : fin
  task automatic xfer(input logic [7:0] op, input logic [23:0] a, input logic [15:0] n, input logic m3);
    go(op, a, n, m3);
    fin();
  endtask : xfer
  task automatic rd_chk(input logic [19:0] a, input int n);
    chkv("read count", 20'(n), 20'(rd_q.size()));
    for (int i = 0; i < n; i++) begin
      if (rd_q.size() > 0) chkv("read data", 20'(mem(a + 20'(i))), 20'(rd_q.pop_front()));
    end
    rd_q.delete();
  endtask : rd_chk
  task automatic wrap_up;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  // Watchdog well past the longest expected run
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    $display("mismatch watchdog expected done seen hang");
    wrap_up();
  end
  // Test sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      xfer(R_OP[t], R_AD[t], 16'h0003, t[0]);
      rd_chk(R_AD[t][19:0], 3);
      chkv("clock mode", 20'(t[0]), 20'(dev_mode3));
    end
    for (int t = 0; t < 7; t++) begin
      xfer(C_OP[t], 24'h3ABCDE, 16'h0000, 1'b0);
      chkc(C_EX[t]);
    end
    chkv("cmd addr", 20'hABCDE, cmd_addr);
    chkv("sector", 20'h0000A, 20'(sector));
    chkv("small sector", 20'h000AB, 20'(small_sector));
    xfer(OP_PROG, 24'hAFFFFF, 16'h0002, 1'b0);
    chkv("prog count", 20'h2, 20'(pa_q.size()));
    for (int i = 0; i < 2 && pa_q.size() > 0; i++) begin
      chkv("prog addr", 20'hFFFFF + 20'(i), pa_q.pop_front());
      chkv("prog data", 20'h000A5 + 20'(i), 20'(pd_q.pop_front()));
    end
    xfer(OP_PWRDN, 24'h000000, 16'h0000, 1'b0);
    chkc(CMD_PWR_DN);
    chkv("power down", 20'h1, 20'(pwr_dn));
    xfer(OP_READ, 24'h000010, 16'h0001, 1'b0);
    chkv("read while down", 20'h000FF, 20'(rd_q.size() > 0 ? rd_q[0] : 8'h00));
    rd_q.delete();
    xfer(OP_RES, 24'h000000, 16'h0000, 1'b0);
    chkc(CMD_PWR_UP);
    chkv("power down", 20'h0, 20'(pwr_dn));
    xfer(OP_RES, 24'h000000, 16'h0001, 1'b0);
    chkv("id byte", 20'(ID_BYTE), 20'(rd_q.size() > 0 ? rd_q[0] : 8'h00));
    rd_q.delete();
    wp_n <= 1'b0;
    lock <= 1'b1;
    xfer(OP_WRSR, 24'h000000, 16'h0001, 1'b0);
    wp_n <= 1'b1;
    xfer(OP_WRSR, 24'h000000, 16'h0001, 1'b0);
    chkv("status blocked", 20'h1, 20'(n_blk));
    chkv("status taken", 20'h1, 20'(n_ok));
    chkv("status data", 20'h000A8, 20'(stat_data));
    // Frame cut inside the address, then a clean command
    cmd_q.delete();
    go(OP_SSE_A, 24'h012345, 16'h0000, 1'b0);
    repeat (150) @(posedge clk);
    abort_n <= 1'b0;
    @(posedge clk);
    abort_n <= 1'b1;
    xfer(OP_WREN, 24'h000000, 16'h0000, 1'b0);
    chkc(CMD_WR_EN);
    chkv("stray cmds", 20'h0, 20'(cmd_q.size()));
    // Hold in mid-address must not disturb the read
    go(OP_READ, 24'h000100, 16'h0002, 1'b0);
    repeat (200) @(posedge clk);
    hold_n <= 1'b0;
    repeat (40) @(posedge clk);
    hold_n <= 1'b1;
    fin();
    rd_chk(20'h00100, 2);
    wrap_up();
  end
endmodule : sfc_tb

// >>> rtl/sfc_device.sv
// Flash command front end: frames opcodes, addresses and data on the serial link
// Operation
// - Capture on rising edge, launch on falling
// - Dual commands drive both data lines
// - Active only while select low
// - Write-protect pin low enables status lock
// - Hold low freezes serial progress
// - Select fall starts byte framing, first opcode
// - Clock level at select fall picks mode
// - Read, fast, dual-out reads: address then data
// - Page program: address then data bytes
// - Erase opcodes, sector ones take address
// - Top four address bits ignored
// - Don't-care bytes accepted with any value
// - Power-down enter and exit, ID read
// - Sectors 64 KB, small sectors 4 KB
// - Read address increments and wraps
// - Dual bytes: odd bits io0, even io1
// - Last two dual I/O dummies released
`timescale 1ns/100ps
module sfc_device
  import sfc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Serial link
  sfc_if.device link,
  // Array read port
  output logic [MEM_ABITS-1:0] o_rd_addr,
  input wire logic [7:0] i_rd_data,
  input wire logic [7:0] i_id_data,
  // Decoded commands
  output logic o_cmd_valid,
  output sfc_cmd_t o_cmd,
  output logic [MEM_ABITS-1:0] o_cmd_addr,
  output logic [3:0] o_sector,
  output logic [7:0] o_small_sector,
  // Program data
  output logic o_prog_valid,
  output logic [MEM_ABITS-1:0] o_prog_addr,
  output logic [7:0] o_prog_data,
  // Status write
  input wire logic i_status_write_lock_bit,
  output logic o_stat_valid,
  output logic o_stat_blocked,
  output logic [7:0] o_stat_data,
  // Device state
  output logic o_mode3,
  output logic o_power_down
);
  sfc_dst_t st_q;
  logic sck_q;
  logic cs_q;
  logic [7:0] op_q;
  logic [7:0] sh_q;
  logic [7:0] osh_q;
  logic [23:0] addr_q;
  logic [4:0] cnt_q;
  logic [2:0] obit_q;
  logic [MEM_ABITS-1:0] pa_q;
  logic dual_q;
  logic dio_q;
  logic id_q;
  logic drv0_q;
  logic drv1_q;
  logic sel;
  logic rise;
  logic fall;
  logic cs_fall;
  logic addr_done;
  logic byte_done;
  logic [4:0] step;
  logic [4:0] dummy_last;
  logic [7:0] byte_in;
  logic [23:0] addr_in;
  logic [7:0] rd_byte;

  // Edge qualification; deselect or hold blocks both clock edges, but hold does not block the select fall
  assign sel = ~link.cs_n & link.hold_n;
  assign rise = sel & link.sck & ~sck_q & (st_q != D_IDLE);
  assign fall = sel & ~link.sck & sck_q & (st_q != D_IDLE);
  assign cs_fall = ~link.cs_n & cs_q;
  // Shift paths; dual I/O address puts the higher bit on io1
  assign step = dio_q ? 5'h02 : 5'h01;
  assign byte_in = {sh_q[6:0], link.io0};
  assign addr_in = dio_q ? {addr_q[21:0], link.io1, link.io0} : {addr_q[22:0], link.io0};
  assign addr_done = rise & (st_q == D_ADDR) & ((cnt_q + step) == ADDR_BITS);
  assign byte_done = cnt_q == (BYTE_BITS - 5'h01);
  assign dummy_last = (dio_q ? DIO_DUMMY_CLKS : FAST_DUMMY_CLKS) - 5'h01;
  assign rd_byte = id_q ? i_id_data : i_rd_data;

  // Previous pin levels for edge detection
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sck_q <= link.sck;
      cs_q <= link.cs_n;
    end
  end

  // Clock level at select fall fixes the mode for the transaction
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_mode3 <= 1'b0;
    end else if (cs_fall) begin
      o_mode3 <= link.sck;
    end
  end

  // Command framing, decode and dispatch
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_q <= D_IDLE;
      op_q <= BYTE_RST;
      sh_q <= BYTE_RST;
      addr_q <= '0;
      cnt_q <= '0;
      pa_q <= ADDR_RST;
      dual_q <= 1'b0;
      dio_q <= 1'b0;
      id_q <= 1'b0;
      o_power_down <= 1'b0;
      o_cmd_valid <= 1'b0;
      o_cmd <= CMD_NONE;
      o_cmd_addr <= ADDR_RST;
      o_sector <= '0;
      o_small_sector <= '0;
      o_prog_valid <= 1'b0;
      o_prog_addr <= ADDR_RST;
      o_prog_data <= BYTE_RST;
      o_stat_valid <= 1'b0;
      o_stat_blocked <= 1'b0;
      o_stat_data <= BYTE_RST;
    end else begin
      o_cmd_valid <= 1'b0;
      o_prog_valid <= 1'b0;
      o_stat_valid <= 1'b0;
      o_stat_blocked <= 1'b0;
      if (link.cs_n) begin
        st_q <= D_IDLE;
      end else if (cs_fall) begin
        st_q <= D_OPC;
        cnt_q <= '0;
        dual_q <= 1'b0;
        dio_q <= 1'b0;
        id_q <= 1'b0;
      end else if (rise) begin
        case (st_q)
          D_OPC: begin
            sh_q <= byte_in;
            cnt_q <= cnt_q + 5'h01;
            if (byte_done) begin
              cnt_q <= '0;
              op_q <= byte_in;
              st_q <= D_IGNORE;
              if (o_power_down) begin
                // Asleep, only the wake opcode is heard
                if (byte_in == OP_RES) begin
                  o_power_down <= 1'b0;
                  o_cmd <= CMD_PWR_UP;
                  o_cmd_valid <= 1'b1;
                end
              end else begin
                case (byte_in)
                  OP_READ, OP_FAST, OP_SSE_A, OP_SSE_B, OP_SE, OP_PROG: st_q <= D_ADDR;
                  OP_DOUT: begin
                    st_q <= D_ADDR;
                    dual_q <= 1'b1;
                  end
                  OP_DIO: begin
                    st_q <= D_ADDR;
                    dual_q <= 1'b1;
                    dio_q <= 1'b1;
                  end
                  OP_RES: begin
                    st_q <= D_ADDR;
                    id_q <= 1'b1;
                  end
                  OP_CE_A, OP_CE_B: begin
                    o_cmd <= CMD_CE;
                    o_cmd_valid <= 1'b1;
                  end
                  OP_WREN: begin
                    o_cmd <= CMD_WR_EN;
                    o_cmd_valid <= 1'b1;
                  end
                  OP_WRDI: begin
                    o_cmd <= CMD_WR_DIS;
                    o_cmd_valid <= 1'b1;
                  end
                  OP_PWRDN: begin
                    o_power_down <= 1'b1;
                    o_cmd <= CMD_PWR_DN;
                    o_cmd_valid <= 1'b1;
                  end
                  OP_WRSR: st_q <= D_DIN;
                  default: st_q <= D_IGNORE;
                endcase
              end
            end
          end
          D_ADDR: begin
            addr_q <= addr_in;
            cnt_q <= cnt_q + step;
            if (addr_done) begin
              cnt_q <= '0;
              st_q <= D_IGNORE;
              // Only the low twenty bits locate a byte
              o_cmd_addr <= addr_in[MEM_ABITS-1:0];
              o_sector <= addr_in[SECT_LSB+3:SECT_LSB];
              o_small_sector <= addr_in[SSECT_LSB+7:SSECT_LSB];
              pa_q <= addr_in[MEM_ABITS-1:0];
              case (op_q)
                OP_READ, OP_RES: st_q <= D_DOUT;
                OP_FAST, OP_DOUT, OP_DIO: st_q <= D_DUMMY;
                OP_PROG: st_q <= D_DIN;
                OP_SSE_A, OP_SSE_B: begin
                  o_cmd <= CMD_SSE;
                  o_cmd_valid <= 1'b1;
                end
                OP_SE: begin
                  o_cmd <= CMD_SE;
                  o_cmd_valid <= 1'b1;
                end
                default: st_q <= D_IGNORE;
              endcase
            end
          end
          D_DUMMY: begin
            // Dummy values are never looked at
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == dummy_last) begin
              st_q <= D_DOUT;
            end
          end
          D_DIN: begin
            sh_q <= byte_in;
            cnt_q <= cnt_q + 5'h01;
            if (byte_done) begin
              cnt_q <= '0;
              if (op_q == OP_PROG) begin
                o_prog_valid <= 1'b1;
                o_prog_data <= byte_in;
                o_prog_addr <= pa_q;
                pa_q <= pa_q + 20'h00001;
              end else begin
                st_q <= D_IGNORE;
                if (!link.wp_n && i_status_write_lock_bit) begin
                  o_stat_blocked <= 1'b1;
                end else begin
                  o_stat_valid <= 1'b1;
                  o_stat_data <= byte_in;
                end
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Read address streams forward and wraps at the top of the array
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rd_addr <= ADDR_RST;
    end else if (addr_done) begin
      o_rd_addr <= addr_in[MEM_ABITS-1:0];
    end else if (fall && st_q == D_DOUT && obit_q == 3'h0 && !id_q) begin
      o_rd_addr <= o_rd_addr + 20'h00001;
    end
  end

  // Output shifter; a new byte is fetched on the fall after the last one ends
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      osh_q <= BYTE_RST;
      obit_q <= '0;
      drv0_q <= 1'b0;
      drv1_q <= 1'b0;
      link.d_io0_o <= 1'b0;
      link.d_io1_o <= 1'b0;
    end else if (st_q != D_DOUT) begin
      obit_q <= '0;
      drv0_q <= 1'b0;
      drv1_q <= 1'b0;
    end else if (fall) begin
      drv1_q <= 1'b1;
      drv0_q <= dual_q;
      if (obit_q == 3'h0) begin
        if (dual_q) begin
          link.d_io0_o <= rd_byte[7];
          link.d_io1_o <= rd_byte[6];
          osh_q <= {rd_byte[5:0], 2'b00};
          obit_q <= 3'h3;
        end else begin
          link.d_io1_o <= rd_byte[7];
          osh_q <= {rd_byte[6:0], 1'b0};
          obit_q <= 3'h7;
        end
      end else begin
        obit_q <= obit_q - 3'h1;
        if (dual_q) begin
          link.d_io0_o <= osh_q[7];
          link.d_io1_o <= osh_q[6];
          osh_q <= {osh_q[5:0], 2'b00};
        end else begin
          link.d_io1_o <= osh_q[7];
          osh_q <= {osh_q[6:0], 1'b0};
        end
      end
    end
  end

  // Drivers let go at once on deselect or hold, a cycle after the cause
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      link.d_io0_oe <= 1'b0;
      link.d_io1_oe <= 1'b0;
    end else begin
      link.d_io0_oe <= drv0_q & sel;
      link.d_io1_oe <= drv1_q & sel;
    end
  end
endmodule : sfc_device

// >>> rtl/sfc_host.sv
// Host controller end: drives select, serial clock and data lines
`timescale 1ns/100ps
module sfc_host
  import sfc_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Serial link
  sfc_if.host link,
  // Transfer request
  input wire logic i_start,
  input wire logic [7:0] i_opcode,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_nbytes,
  input wire logic i_mode3,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  // Write data
  input wire logic [7:0] i_wr_data,
  output logic o_wr_req,
  // Read data
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic o_busy
);
  sfc_hst_t st_q;
  logic [31:0] tx_q;
  logic [7:0] rx_q;
  logic [4:0] cnt_q;
  logic [4:0] dum_q;
  logic [15:0] left_q;
  logic [15:0] div_q;
  logic skip_q;
  logic w2_q;
  logic pair_q;
  logic has_addr_q;
  logic dual_q;
  logic dio_q;
  logic rd_q;
  logic idle_q;
  logic tick;
  logic [4:0] step;
  logic [4:0] nstep;
  logic [7:0] rx_in;

  assign tick = div_q == 16'(HALF - 1);
  assign step = dio_q ? 5'h02 : 5'h01;
  assign nstep = dual_q ? 5'h02 : 5'h01;
  assign rx_in = dual_q ? {rx_q[5:0], link.io0, link.io1} : {rx_q[6:0], link.io1};

  // Sequencer; data changes on falls and is sampled on rises
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_q <= H_IDLE;
      tx_q <= '0;
      rx_q <= BYTE_RST;
      cnt_q <= '0;
      dum_q <= '0;
      left_q <= '0;
      div_q <= '0;
      skip_q <= 1'b0;
      w2_q <= 1'b0;
      pair_q <= 1'b0;
      has_addr_q <= 1'b0;
      dual_q <= 1'b0;
      dio_q <= 1'b0;
      rd_q <= 1'b0;
      idle_q <= 1'b0;
      link.cs_n <= 1'b1;
      link.sck <= 1'b0;
      link.hold_n <= 1'b1;
      link.wp_n <= 1'b1;
      o_wr_req <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= BYTE_RST;
      o_busy <= 1'b0;
    end else begin
      o_wr_req <= 1'b0;
      o_rd_valid <= 1'b0;
      link.hold_n <= i_hold_n;
      link.wp_n <= i_wp_n;
      if (st_q == H_IDLE) begin
        link.sck <= i_mode3;
        div_q <= '0;
        if (i_start) begin
          link.cs_n <= 1'b0;
          o_busy <= 1'b1;
          tx_q <= {i_opcode, i_addr};
          st_q <= H_OPC;
          cnt_q <= '0;
          skip_q <= i_mode3;
          idle_q <= i_mode3;
          left_q <= i_nbytes;
          has_addr_q <= (i_opcode == OP_RES) ? (i_nbytes != 16'h0000) :
            (i_opcode inside {OP_READ, OP_FAST, OP_DOUT, OP_DIO, OP_SSE_A, OP_SSE_B, OP_SE, OP_PROG});
          dum_q <= (i_opcode == OP_DIO) ? DIO_DUMMY_CLKS :
            ((i_opcode == OP_FAST || i_opcode == OP_DOUT) ? FAST_DUMMY_CLKS : 5'h00);
          dual_q <= i_opcode == OP_DOUT || i_opcode == OP_DIO;
          dio_q <= i_opcode == OP_DIO;
          rd_q <= !(i_opcode == OP_PROG || i_opcode == OP_WRSR);
        end
      // Raw request too, so no edge slips out in the cycle the pin goes low
      end else if (link.hold_n && i_hold_n) begin
        div_q <= tick ? 16'h0000 : div_q + 16'h0001;
        if (tick) begin
          if (st_q == H_END) begin
            if (link.sck == idle_q) begin
              link.cs_n <= 1'b1;
              o_busy <= 1'b0;
              st_q <= H_IDLE;
            end else begin
              link.sck <= ~link.sck;
            end
          end else if (!link.sck) begin
            link.sck <= 1'b1;
            w2_q <= (st_q == H_ADDR && dio_q);
            case (st_q)
              H_OPC: begin
                cnt_q <= cnt_q + 5'h01;
                if (cnt_q == BYTE_BITS - 5'h01) begin
                  cnt_q <= '0;
                  st_q <= has_addr_q ? H_ADDR : (left_q != 16'h0000 ? H_DATA : H_END);
                end
              end
              H_ADDR: begin
                cnt_q <= cnt_q + step;
                if (cnt_q + step == ADDR_BITS) begin
                  cnt_q <= '0;
                  st_q <= dum_q != 5'h00 ? H_DUMMY : (left_q != 16'h0000 ? H_DATA : H_END);
                end
              end
              H_DUMMY: begin
                cnt_q <= cnt_q + 5'h01;
                if (cnt_q == dum_q - 5'h01) begin
                  cnt_q <= '0;
                  st_q <= left_q != 16'h0000 ? H_DATA : H_END;
                end
              end
              H_DATA: begin
                cnt_q <= cnt_q + nstep;
                if (rd_q) begin
                  rx_q <= rx_in;
                end
                if (cnt_q + nstep == BYTE_BITS) begin
                  cnt_q <= '0;
                  left_q <= left_q - 16'h0001;
                  o_rd_valid <= rd_q;
                  o_rd_data <= rx_in;
                  if (left_q == 16'h0001) begin
                    st_q <= H_END;
                  end
                end
              end
              default: ;
            endcase
          end else begin
            link.sck <= 1'b0;
            // Pair select moves on a fall, so io0 never changes while the clock is high
            pair_q <= st_q == H_ADDR && dio_q;
            if (skip_q) begin
              skip_q <= 1'b0;
            end else if (st_q == H_DATA && !rd_q && cnt_q == 5'h00) begin
              tx_q <= {i_wr_data, 24'h000000};
              o_wr_req <= 1'b1;
            end else begin
              tx_q <= w2_q ? {tx_q[29:0], 2'b00} : {tx_q[30:0], 1'b0};
            end
          end
        end
      end
    end
  end

  // Line drivers; both released for the closing dual I/O dummies and reads
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      link.h_io0_o <= 1'b0;
      link.h_io1_o <= 1'b0;
      link.h_io0_oe <= 1'b0;
      link.h_io1_oe <= 1'b0;
    end else begin
      link.h_io1_o <= tx_q[31];
      link.h_io0_o <= pair_q ? tx_q[30] : tx_q[31];
      link.h_io0_oe <= st_q == H_OPC || st_q == H_ADDR || (st_q == H_DATA && !rd_q) ||
        (st_q == H_DUMMY && (dio_q ? cnt_q < DIO_DRIVE_CLKS : !dual_q));
      link.h_io1_oe <= dio_q && (st_q == H_ADDR || (st_q == H_DUMMY && cnt_q < DIO_DRIVE_CLKS));
    end
  end
endmodule : sfc_host

// >>> rtl/sfc_if.sv
// Serial link between host controller and flash front end
`timescale 1ns/100ps
interface sfc_if;
  logic cs_n;
  logic sck;
  logic hold_n;
  logic wp_n;
  logic h_io0_o;
  logic h_io0_oe;
  logic h_io1_o;
  logic h_io1_oe;
  logic d_io0_o;
  logic d_io0_oe;
  logic d_io1_o;
  logic d_io1_oe;
  logic io0;
  logic io1;
  // Resolved line levels; an undriven line reads high like a pulled-up wire
  assign io0 = d_io0_oe ? d_io0_o : (h_io0_oe ? h_io0_o : 1'b1);
  assign io1 = d_io1_oe ? d_io1_o : (h_io1_oe ? h_io1_o : 1'b1);
  modport host (output cs_n, sck, hold_n, wp_n, h_io0_o, h_io0_oe, h_io1_o, h_io1_oe, input io0, io1);
  modport device (input cs_n, sck, hold_n, wp_n, io0, io1, output d_io0_o, d_io0_oe, d_io1_o, d_io1_oe);
endinterface : sfc_if

// >>> rtl/sfc_pkg.sv
// Shared opcodes, counts, types and states for the serial flash front end
package sfc_pkg;
  // Command opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DOUT = 8'h3B;
  localparam logic [7:0] OP_DIO = 8'hBB;
  localparam logic [7:0] OP_SSE_A = 8'h20;
  localparam logic [7:0] OP_SSE_B = 8'hD7;
  localparam logic [7:0] OP_SE = 8'hD8;
  localparam logic [7:0] OP_CE_A = 8'h60;
  localparam logic [7:0] OP_CE_B = 8'hC7;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_PWRDN = 8'hB9;
  localparam logic [7:0] OP_RES = 8'hAB;
  localparam logic [7:0] OP_WRSR = 8'h01;
  // Bit and clock counts
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] FAST_DUMMY_CLKS = 5'h08;
  localparam logic [4:0] DIO_DUMMY_CLKS = 5'h04;
  localparam logic [4:0] DIO_DRIVE_CLKS = 5'h02;
  localparam int MEM_ABITS = 20;
  localparam int SECT_LSB = 16;
  localparam int SSECT_LSB = 12;
  localparam int SCK_HALF_CYCLES = 4;
  // Values after reset
  localparam logic [19:0] ADDR_RST = 20'h00000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Decoded commands passed to the array side
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000, CMD_WR_EN = 3'b001, CMD_WR_DIS = 3'b010, CMD_SSE = 3'b011,
    CMD_SE = 3'b100, CMD_CE = 3'b101, CMD_PWR_DN = 3'b110, CMD_PWR_UP = 3'b111
  } sfc_cmd_t;
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_OPC = 3'b001, D_ADDR = 3'b010, D_DUMMY = 3'b011,
    D_DOUT = 3'b100, D_DIN = 3'b101, D_IGNORE = 3'b110
  } sfc_dst_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_OPC = 3'b001, H_ADDR = 3'b010, H_DUMMY = 3'b011,
    H_DATA = 3'b100, H_END = 3'b101
  } sfc_hst_t;
endpackage : sfc_pkg
